// [hdl/ebc_pkg.sv]
package ebc_pkg;
    // transfer size encodings on the size pins
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_THREE = 2'h3;
    // size acknowledge encodings, active low
    localparam logic [1:0] ACK_WAIT = 2'h3;
    localparam logic [1:0] ACK_PORT8 = 2'h2;
    localparam logic [1:0] ACK_PORT16 = 2'h1;
    localparam logic [1:0] ACK_RSVD = 2'h0;
    // chip-select acknowledge field codes
    localparam logic [3:0] CS_ACK_FAST = 4'he;
    localparam logic [3:0] CS_ACK_EXTERNAL = 4'hf;
    // internal module access length in clocks
    localparam logic [1:0] INT_CYCLES = 2'h2;
    // monitor timeouts in system clocks
    localparam logic [6:0] BMT_64 = 7'h40;
    localparam logic [6:0] BMT_32 = 7'h20;
    localparam logic [6:0] BMT_16 = 7'h10;
    localparam logic [6:0] BMT_8 = 7'h08;
    // first half-clock state number loaded on accept: two states per clock
    localparam logic [7:0] STATE_ONE = 8'h01;
    typedef enum logic [2:0] {
        EBC_IDLE, EBC_INT, EBC_ADDR, EBC_STROBE, EBC_WAIT, EBC_DONE
    } ebc_state_e;
    typedef logic [23:0] ebc_addr_t;
endpackage : ebc_pkg

// [hdl/ebc_sync_if.sv]
interface ebc_sync_if;
    logic [1:0] size_ack_n;
    logic bus_error_n;
    logic halt_n;
    modport src (output size_ack_n, output bus_error_n, output halt_n);
    modport dst (input size_ack_n, input bus_error_n, input halt_n);
endinterface : ebc_sync_if

// [hdl/ebc_sync.sv]
module ebc_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // raw pins
    input wire logic [1:0] size_ack_n,
    input wire logic bus_error_n,
    input wire logic halt_n,
    // synchronised view
    ebc_sync_if.src sync
);
    logic [3:0] meta_r;
    logic [3:0] stab_r;
    // two-stage capture, first stage read only by second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= 4'hf;
            stab_r <= 4'hf;
        end else begin
            meta_r <= {halt_n, bus_error_n, size_ack_n}; // RULE_23
            stab_r <= meta_r;
        end
    end
    assign sync.size_ack_n = stab_r[1:0];
    assign sync.bus_error_n = stab_r[2];
    assign sync.halt_n = stab_r[3];
endmodule : ebc_sync

// [hdl/ebc_ctrl.sv]
// Overview of operation
// (RULE_01) internal accesses finish in two clocks
// (RULE_02) regular external cycle three clocks, no waits
// (RULE_03) wait whole clocks until acknowledge low
// (RULE_04) no termination and no monitor: wait forever
// (RULE_05) bus error with halt acts as bus error
// (RULE_06) monitor raises bus error after selected timeout
// (RULE_07) drive address and size; outside decodes lanes
// (RULE_08) peripheral moves data then acknowledges port width
// (RULE_09) word reads fetch two bytes, byte one
// (RULE_10) word writes store two bytes, byte one
// (RULE_11) fast termination completes in two clocks
// (RULE_12) software programs overlapping chip-selects identically
// (RULE_13) acknowledge from chip-select logic or external
// (RULE_14) external acknowledge always honoured; fast cycles here ignore it
// (RULE_15) acknowledge held low gives three-clock cycles
// (RULE_16) fast termination only with fast code
// (RULE_17) fast device has data by state four
// (RULE_18) fast cycles: data strobe on reads only
// (RULE_19) software sets strobe select for fast writes
// (RULE_20) timing counted in half-clock states
// (RULE_21) acknowledge encoding: wait, 8-bit, 16-bit, reserved
// (RULE_22) 8-bit ports sit on upper data lines
// (RULE_23) synchronise acknowledge, bus error and halt
module ebc_ctrl
    import ebc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_internal,
    input wire logic req_write,
    input wire ebc_pkg::ebc_addr_t req_addr,
    input wire logic [1:0] req_size,
    input wire logic [15:0] req_wdata,
    input wire logic [3:0] cs_ack_field,
    // configuration
    input wire logic monitor_enable,
    input wire logic [1:0] monitor_timeout_select,
    // response side
    output logic rsp_valid,
    output logic rsp_bus_error,
    output logic rsp_port16,
    output logic [15:0] rsp_rdata,
    output logic [7:0] rsp_state_count,
    // external bus pins
    output logic [23:0] ext_addr,
    output logic [1:0] transfer_size,
    output logic address_strobe_n,
    output logic data_strobe_n,
    output logic read_write,
    output logic bus_reference_clock,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n,
    input wire logic [1:0] size_ack_n,
    input wire logic bus_error_n,
    input wire logic halt_n
);
    import ebc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    ebc_sync_if sync_bus ();

    ebc_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .size_ack_n(size_ack_n),
        .bus_error_n(bus_error_n),
        .halt_n(halt_n),
        .sync(sync_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] timeout_of(input logic [1:0] sel);
        logic [6:0] t;
        t = BMT_64;
        case (sel)
            2'h0: t = BMT_64;
            2'h1: t = BMT_32;
            2'h2: t = BMT_16;
            default: t = BMT_8;
        endcase
        return t;
    endfunction : timeout_of

    ebc_state_e state_r, state_nxt;
    logic write_r;
    logic fast_r;
    logic internal_r;
    logic [6:0] mon_cnt_r;
    logic [7:0] phase_cnt_r;
    logic clk_half_r;
    ebc_addr_t addr_r;
    logic [1:0] size_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic bus_err_r;
    logic port16_r;
    logic done_r;

    ////////////////////////////////////////////////////////////////////////
    // termination decode
    wire logic [1:0] ack_sync = sync_bus.size_ack_n;
    wire logic ext_ack = (ack_sync == ACK_PORT8) || (ack_sync == ACK_PORT16); // RULE_21
    wire logic ext_ack16 = (ack_sync == ACK_PORT16); // RULE_21
    // bus error wins regardless of halt
    wire logic ext_bus_error_n = !sync_bus.bus_error_n; // RULE_05
    wire logic mon_bus_error_n = monitor_enable &&
        (mon_cnt_r >= timeout_of(monitor_timeout_select)); // RULE_06
    wire logic any_bus_error_n = ext_bus_error_n || mon_bus_error_n;
    wire logic cs_fast = (cs_ack_field == CS_ACK_FAST); // RULE_16
    // external lines honoured in the strobe and wait states, never in fast cycles
    wire logic term_wait = ext_ack || any_bus_error_n; // RULE_14 RULE_03 RULE_04
    wire logic is_byte = (req_size == SIZE_BYTE);
    wire logic accept = req_valid && (state_r == EBC_IDLE);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            EBC_IDLE: begin
                if (req_valid) begin
                    state_nxt = req_internal ? EBC_INT : EBC_ADDR;
                end
            end
            EBC_INT: state_nxt = EBC_DONE; // RULE_01
            EBC_ADDR: state_nxt = fast_r ? EBC_DONE : EBC_STROBE; // RULE_11
            EBC_STROBE: state_nxt = term_wait ? EBC_DONE : EBC_WAIT; // RULE_02 RULE_15
            EBC_WAIT: state_nxt = term_wait ? EBC_DONE : EBC_WAIT; // RULE_03 RULE_04
            EBC_DONE: state_nxt = EBC_IDLE;
            default: state_nxt = EBC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= EBC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            write_r <= 1'b0;
            fast_r <= 1'b0;
            internal_r <= 1'b0;
            addr_r <= '0;
            size_r <= SIZE_BYTE;
            wdata_r <= 16'h0000;
        end else if (accept) begin
            write_r <= req_write;
            fast_r <= cs_fast && !req_internal; // RULE_13 RULE_11
            internal_r <= req_internal;
            addr_r <= req_addr; // RULE_07
            // byte op moves one byte, else two
            size_r <= is_byte ? SIZE_BYTE : SIZE_WORD; // RULE_09 RULE_10
            wdata_r <= req_wdata;
        end
    end

    // monitor counts clocks in the strobe and wait states
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mon_cnt_r <= 7'h00;
        end else if (state_r == EBC_STROBE || state_r == EBC_WAIT) begin
            if (mon_cnt_r != BMT_64) begin
                mon_cnt_r <= mon_cnt_r + 7'h01;
            end
        end else begin
            mon_cnt_r <= 7'h00;
        end
    end

    // half-clock state numbering
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_cnt_r <= 8'h00;
        end else if (accept) begin
            phase_cnt_r <= STATE_ONE; // RULE_20
        end else if (state_r != EBC_IDLE && phase_cnt_r < 8'hfe) begin
            phase_cnt_r <= phase_cnt_r + 8'h02; // RULE_20
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_half_r <= 1'b0;
        end else begin
            clk_half_r <= !clk_half_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion and data capture
    wire logic finishing = (state_nxt == EBC_DONE) && (state_r != EBC_DONE);
    wire logic end_err = (state_r == EBC_STROBE || state_r == EBC_WAIT) && any_bus_error_n;
    wire logic end16 = fast_r || internal_r || (ext_ack16 && !any_bus_error_n);
    // 8-bit ports sit on the upper lanes
    wire logic [15:0] rd_lane = (end16 || !ext_ack) ? data_in
        : {data_in[15:8], data_in[15:8]}; // RULE_22

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
            bus_err_r <= 1'b0;
            port16_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= finishing;
            if (finishing) begin
                bus_err_r <= end_err;
                port16_r <= end16;
                if (!write_r) begin
                    rdata_r <= rd_lane; // RULE_08 RULE_17
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire logic ext_active = (state_r == EBC_ADDR || state_r == EBC_STROBE ||
        state_r == EBC_WAIT) && !internal_r;
    wire logic strobe_phase = (state_r == EBC_STROBE || state_r == EBC_WAIT) ||
        (state_r == EBC_ADDR && fast_r);

    assign req_ready = (state_r == EBC_IDLE);
    assign rsp_valid = done_r;
    assign rsp_bus_error = bus_err_r;
    assign rsp_port16 = port16_r;
    assign rsp_rdata = rdata_r;
    assign rsp_state_count = phase_cnt_r;
    assign ext_addr = addr_r; // RULE_07
    assign transfer_size = size_r; // RULE_07
    assign address_strobe_n = !ext_active;
    // fast writes leave data strobe negated
    assign data_strobe_n = !(strobe_phase && !(fast_r && write_r)); // RULE_18
    assign read_write = !write_r;
    assign bus_reference_clock = clk_half_r;
    assign data_out = wdata_r;
    assign data_oe_n = !(ext_active && write_r);
endmodule : ebc_ctrl

// [dv/ebc_ctrl_monitor.sv]
module ebc_ctrl_monitor
    import ebc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // request and configuration
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_internal,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [3:0] cs_ack_field,
    input wire logic monitor_enable,
    input wire logic [1:0] monitor_timeout_select,
    // response and bus pins
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_state_count,
    input wire logic read_write,
    input wire logic data_oe_n,
    input wire logic [1:0] transfer_size,
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic bus_reference_clock,
    input wire logic [1:0] size_ack_n,
    input wire logic bus_error_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire take = req_valid && req_ready;
    wire ext = take && !req_internal;
    wire fast = ext && cs_ack_field == CS_ACK_FAST;
    // no way for a regular cycle to end
    wire stall = size_ack_n == ACK_WAIT && bus_error_n && !monitor_enable
        && cs_ack_field != CS_ACK_FAST;
    ////////////////////////////////////////////////////////////////////////
    property p_int;
        take && req_internal |-> ##1 address_strobe_n && !rsp_valid ##1 rsp_valid;
    endproperty
    a_int: assert property (p_int) else $error("bad internal length");
    property p_fast; fast |-> ##1 !rsp_valid ##1 rsp_valid; endproperty
    a_fast: assert property (p_fast) else $error("bad fast length");
    property p_reg; ext && cs_ack_field != CS_ACK_FAST |-> ##1 !rsp_valid [*2]; endproperty
    a_reg: assert property (p_reg) else $error("regular cycle too short");
    property p_wait; stall [*3] ##0 !address_strobe_n |=> !address_strobe_n; endproperty
    a_wait: assert property (p_wait) else $error("cycle ended without ack");
    property p_mon;
        $fell(address_strobe_n) && monitor_enable && monitor_timeout_select == 2'h3
            |-> ##[1:16] address_strobe_n;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor did not end cycle");
    property p_dswr; fast && req_write |-> ##1 data_strobe_n [*3]; endproperty
    a_dswr: assert property (p_dswr) else $error("strobe on fast write");
    property p_dsrd; fast && !req_write |-> ##1 !data_strobe_n; endproperty
    a_dsrd: assert property (p_dsrd) else $error("no strobe on fast read");
    property p_size;
        ext |-> ##1 transfer_size == ($past(req_size) == SIZE_BYTE ? SIZE_BYTE : SIZE_WORD);
    endproperty
    a_size: assert property (p_size) else $error("bad transfer size");
    property p_clk; $past(rst_n) |-> bus_reference_clock != $past(bus_reference_clock); endproperty
    a_clk: assert property (p_clk) else $error("bus clock stuck");
    // data lanes driven only while address strobe is asserted on a write
    property p_oe; data_oe_n == !(!address_strobe_n && !read_write); endproperty
    a_oe: assert property (p_oe) else $error("data enable wrong");
    property p_phase;
        take |=> rsp_state_count == STATE_ONE ##1 rsp_state_count == STATE_ONE + 8'h02;
    endproperty
    a_phase: assert property (p_phase) else $error("bad state numbering");
    c_fast: cover property (fast && !req_write);
    c_int: cover property (take && req_internal);
    c_long: cover property (!address_strobe_n [*8]);
endmodule : ebc_ctrl_monitor

bind ebc_ctrl ebc_ctrl_monitor i_ebc_ctrl_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_internal(req_internal),
    .req_write(req_write), .req_size(req_size), .cs_ack_field(cs_ack_field),
    .monitor_enable(monitor_enable), .monitor_timeout_select(monitor_timeout_select),
    .rsp_valid(rsp_valid), .rsp_state_count(rsp_state_count), .read_write(read_write),
    .data_oe_n(data_oe_n), .transfer_size(transfer_size), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .bus_reference_clock(bus_reference_clock),
    .size_ack_n(size_ack_n), .bus_error_n(bus_error_n));

// [dv/ebc_dev_model.sv]
module ebc_dev_model
    import ebc_pkg::*;
(
    // bus side
    input wire logic ref_clk,
    input wire logic address_strobe_n,
    input wire logic read_write,
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] data_out,
    // mode 0 ack, 1 ack held low, 2 silent, 3 bus error
    input wire logic [1:0] mode,
    input wire logic [7:0] dly,
    input wire logic port8,
    input wire logic halt_too,
    // answers
    output logic [1:0] size_ack_n,
    output logic bus_error_n,
    output logic halt_n,
    output logic [15:0] data_in,
    output logic [15:0] wr_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    logic fire;
    initial begin
        {size_ack_n, bus_error_n, halt_n, data_in} = {ACK_WAIT, 2'h3, 16'h0};
    end
    always @(posedge ref_clk) begin
        #1;
        n = address_strobe_n ? 0 : n + 1;
        fire = !address_strobe_n && n > dly;
        if (mode == 2'h1 || (fire && mode == 2'h0)) begin
            size_ack_n = port8 ? ACK_PORT8 : ACK_PORT16;
        end else begin
            size_ack_n = ACK_WAIT;
        end
        bus_error_n = !(fire && mode == 2'h3);
        halt_n = !(fire && mode == 2'h3 && halt_too);
        // data lines keep moving outside read cycles
        if (!address_strobe_n && read_write) begin
            data_in = {ext_addr[7:0], ~ext_addr[7:0]};
        end else begin
            data_in = ~data_in;
        end
        if (!address_strobe_n && !read_write) begin
            wr_seen = data_out;
        end
    end
endmodule : ebc_dev_model

// [dv/external_bus_cycle_control_tb_top.sv]
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module external_bus_cycle_control_tb_top
    import ebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, req_valid, req_internal, req_write, monitor_enable, port8, halt_too;
    logic req_ready, rsp_valid, rsp_bus_error, rsp_port16, read_write, bus_error_n, halt_n;
    logic address_strobe_n;
    logic [1:0] req_size, monitor_timeout_select, size_ack_n, mode;
    logic [3:0] cs_ack_field;
    logic [7:0] dly;
    logic [23:0] ext_addr;
    logic [15:0] req_wdata, data_in, data_out, rsp_rdata, wr_seen;
    ebc_addr_t req_addr;
    int bad_count = 0, checks_done = 0, cyc;
    ebc_ctrl i_ebc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_internal(req_internal), .req_write(req_write),
        .req_addr(req_addr), .req_size(req_size), .req_wdata(req_wdata),
        .cs_ack_field(cs_ack_field), .monitor_enable(monitor_enable),
        .monitor_timeout_select(monitor_timeout_select), .rsp_valid(rsp_valid),
        .rsp_bus_error(rsp_bus_error), .rsp_port16(rsp_port16), .rsp_rdata(rsp_rdata),
        .rsp_state_count(), .ext_addr(ext_addr), .transfer_size(), .read_write(read_write),
        .address_strobe_n(address_strobe_n), .data_strobe_n(), .bus_reference_clock(),
        .data_in(data_in), .data_out(data_out), .data_oe_n(), .size_ack_n(size_ack_n),
        .bus_error_n(bus_error_n), .halt_n(halt_n));
    ebc_dev_model i_ebc_dev_model (.ref_clk(ref_clk), .address_strobe_n(address_strobe_n),
        .read_write(read_write), .ext_addr(ext_addr), .data_out(data_out), .mode(mode),
        .dly(dly), .port8(port8), .halt_too(halt_too), .size_ack_n(size_ack_n),
        .bus_error_n(bus_error_n), .halt_n(halt_n), .data_in(data_in), .wr_seen(wr_seen));
    ////////////////////////////////////////////////////////////////////////
    task automatic go(input logic i, w, input logic [1:0] s, input logic [3:0] c);
        {req_internal, req_write, req_size, cs_ack_field} = {i, w, s, c};
        req_valid = 1'b1;
        @(posedge ref_clk) #1;
        req_valid = 1'b0;
        cyc = 1;
        while (rsp_valid !== 1'b1 && cyc < 300) begin
            @(posedge ref_clk) #1;
            cyc++;
        end
        `CHK("rsp_seen", 1'b1, rsp_valid)
        @(posedge ref_clk) #1;
    endtask : go
    // let the synchroniser settle on the new answer
    task automatic setm(input logic [1:0] m);
        mode = m;
        repeat (3) @(posedge ref_clk) #1;
    endtask : setm
    task automatic t_held;
        setm(2'h1);
        go(1'b1, 1'b0, SIZE_WORD, CS_ACK_EXTERNAL);
        `CHK("int_len", INT_CYCLES, cyc)
        go(1'b0, 1'b0, SIZE_WORD, CS_ACK_EXTERNAL);
        `CHK("held_len", 3, cyc)
        `CHK("port16", 1'b1, rsp_port16)
        `CHK("rd16", {req_addr[7:0], ~req_addr[7:0]}, rsp_rdata)
        go(1'b0, 1'b1, SIZE_LONG, CS_ACK_EXTERNAL);
        `CHK("wr16", req_wdata, wr_seen)
        go(1'b0, 1'b0, SIZE_WORD, CS_ACK_FAST);
        `CHK("fast_len", 2, cyc)
        `CHK("fast_rd", {req_addr[7:0], ~req_addr[7:0]}, rsp_rdata)
        go(1'b0, 1'b1, SIZE_BYTE, CS_ACK_FAST);
        `CHK("fast_wr", 2, cyc)
    endtask : t_held
    task automatic t_wait;
        int c0;
        port8 = 1'b1;
        setm(2'h0);
        go(1'b0, 1'b0, SIZE_BYTE, CS_ACK_EXTERNAL);
        c0 = cyc;
        `CHK("port8", 1'b0, rsp_port16)
        `CHK("rd8", req_addr[7:0], rsp_rdata[15:8])
        dly = 8'h3;
        go(1'b0, 1'b0, SIZE_BYTE, CS_ACK_EXTERNAL);
        `CHK("wait_len", c0 + 3, cyc)
        dly = 8'h64;
        go(1'b0, 1'b1, SIZE_WORD, CS_ACK_EXTERNAL);
        `CHK("no_limit", 1'b1, cyc > 100 && !rsp_bus_error)
    endtask : t_wait
    task automatic t_bus_error_n;
        int c0;
        {dly, halt_too} = {8'h1, 1'b1};
        setm(2'h3);
        go(1'b0, 1'b0, SIZE_WORD, CS_ACK_EXTERNAL);
        c0 = cyc;
        `CHK("bus_error_n_halt", 1'b1, rsp_bus_error)
        halt_too = 1'b0;
        go(1'b0, 1'b0, SIZE_WORD, CS_ACK_EXTERNAL);
        `CHK("bus_error_n_len", c0, cyc)
    endtask : t_bus_error_n
    task automatic t_mon;
        setm(2'h2);
        monitor_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            monitor_timeout_select = k[1:0];
            go(1'b0, 1'b0, SIZE_WORD, CS_ACK_EXTERNAL);
            `CHK("mon_err", 1'b1, rsp_bus_error)
            `CHK("mon_len", 1'b1, cyc >= (64 >> k) && cyc <= (64 >> k) + 8)
        end
    endtask : t_mon
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #160000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_n, req_valid, req_internal, req_write, monitor_enable, port8, halt_too} = 7'h0;
        {req_size, monitor_timeout_select, cs_ack_field, mode, dly} = 16'h0;
        {req_addr, req_wdata} = {24'h00a5c3, 16'hbeef};
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_held();
        t_wait();
        t_bus_error_n();
        t_mon();
        wrap_up();
    end
endmodule : external_bus_cycle_control_tb_top
